// File: common/dio_pkg.sv
// Constants shared by the digital I/O port block: register indices, field widths, reset values.
// Assumes a byte-wide register port with one-cycle read latency and a single 20 MHz clock.
// Behaviour
// - Up to six ports of eight pins, each pin individually directed, read and written.
// - Pin level register returns the synchronised pin level, 0 low, 1 high.
// - Port-function output pins drive the output value register bit.
// - Direction bit 0 input, 1 output, applies in port and peripheral function.
// - Function select 0 gives the pin to the port, 1 to the peripheral.
// - Setting function select never changes the direction bit.
// - Pins with function select 1 never set interrupt flags on ports one and two.
// - Peripheral input follows pin while selected, holds last value once deselected.
// - Only ports one and two have per-pin enable and edge-selected interrupts.
// - Each interrupt port has one shared request line; flags show the source.
// - A pin flag is set when the chosen edge is seen at the pin.
// - Request is high while any flag and enable pair and global enable are set.
// - Hardware never clears flags; software write clears, writing 1 sets a flag.
// - Flags set on transitions only; a flag set during service keeps request high.
// - Output or direction writes making the chosen edge at a pin set its flag.
// - Edge select 0 picks rising, 1 picks falling edge.
// - Enable bit 1 lets its flag reach the request, 0 blocks it.
// - Edge select change toward the current pin level sets the flag.
package dio_pkg;
    localparam int unsigned NUM_PORTS = 6;
    localparam int unsigned NUM_IRQ_PORTS = 2;
    localparam int unsigned PORT_WIDTH = 8;
    localparam int unsigned ADDR_WIDTH = 8;
    localparam int unsigned EVENT_MIN_NS10 = 15;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam logic [7:0] P1_BASE = 8'h20;
    localparam logic [7:0] P2_BASE = 8'h28;
    localparam logic [7:0] P3_BASE = 8'h18;
    localparam logic [7:0] P4_BASE = 8'h1C;
    localparam logic [7:0] P5_BASE = 8'h30;
    localparam logic [7:0] P6_BASE = 8'h34;
    localparam logic [2:0] OFS_PIN_LEVEL = 3'h0;
    localparam logic [2:0] OFS_OUTPUT_VALUE = 3'h1;
    localparam logic [2:0] OFS_DIRECTION = 3'h2;
    localparam logic [2:0] OFS_EDGE_FLAGS = 3'h3;
    localparam logic [2:0] OFS_EDGE_POLARITY = 3'h4;
    localparam logic [2:0] OFS_IRQ_ENABLE = 3'h5;
    localparam logic [2:0] OFS_FUNC_SEL_IRQ = 3'h6;
    localparam logic [2:0] OFS_FUNC_SEL_PLAIN = 3'h3;
    localparam logic [7:0] DIRECTION_RST = 8'h00;
    localparam logic [7:0] FUNC_SEL_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage

// File: rtl/dio_pin_sync.sv
// Two-stage synchroniser for a bank of pin inputs.
// Assumes the pins may change at any time relative to the clock.
`timescale 1ns/100ps
module dio_pin_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] pins_sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_s;

    sync_s state_r;
    sync_s state_nxt;

    always_comb begin
        state_nxt = state_r;
        state_nxt.stage1 = pins_in;
        state_nxt.stage2 = state_r.stage1;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pins_sync_out = state_r.stage2;
endmodule

// File: rtl/dio_ports.sv
// Digital I/O port block: six byte-wide ports, interrupts on the first two.
// Assumes a one-cycle byte register port and a core that supplies the global enable.
`timescale 1ns/100ps
module dio_ports #(
    parameter int unsigned NUM_PORTS = dio_pkg::NUM_PORTS
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [dio_pkg::ADDR_WIDTH-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic global_irq_enable_in,
    input wire logic [NUM_PORTS*8-1:0] pin_in,
    output logic [NUM_PORTS*8-1:0] pin_out,
    output logic [NUM_PORTS*8-1:0] pin_oe_out,
    input wire logic [NUM_PORTS*8-1:0] periph_out_in,
    output logic [NUM_PORTS*8-1:0] periph_in_out,
    output logic [dio_pkg::NUM_IRQ_PORTS-1:0] port_irq_out
);
    localparam int unsigned NP = NUM_PORTS;
    localparam int unsigned NI = dio_pkg::NUM_IRQ_PORTS;

    // The map and the interrupt logic serve between two and six ports only.
    if (NP < NI || NP > dio_pkg::NUM_PORTS) begin : g_bad_ports
        $error("NUM_PORTS must lie between 2 and 6");
    end

    typedef struct packed {
        logic [NP-1:0][7:0] output_value;
        logic [NP-1:0][7:0] direction;
        logic [NP-1:0][7:0] func_sel;
        logic [NI-1:0][7:0] flags;
        logic [NI-1:0][7:0] polarity;
        logic [NI-1:0][7:0] irq_enable;
        logic [NP-1:0][7:0] level_prev;
        logic [NP-1:0][7:0] periph_hold;
        logic [NP-1:0][7:0] pin_drive;
        logic [NP-1:0][7:0] pin_oe;
        logic [NI-1:0] irq;
        logic [7:0] rdata;
    } dio_s;

    dio_s state_r;
    dio_s state_nxt;
    logic [NP*8-1:0] pin_sync;
    logic [NP*8-1:0] level_now;
    logic [7:0] bases [6];

    assign bases[0] = dio_pkg::P1_BASE;
    assign bases[1] = dio_pkg::P2_BASE;
    assign bases[2] = dio_pkg::P3_BASE;
    assign bases[3] = dio_pkg::P4_BASE;
    assign bases[4] = dio_pkg::P5_BASE;
    assign bases[5] = dio_pkg::P6_BASE;

    dio_pin_sync #(
        .WIDTH(NP*8)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .pins_in(pin_in),
        .pins_sync_out(pin_sync)
    );

    // The pad loops the driven level back, so an output pin reads its own drive.
    assign level_now = pin_sync;

    always_comb begin
        logic [7:0] lvl;
        logic [7:0] prev;
        logic [7:0] rise;
        logic [7:0] fall;
        logic [7:0] edge_hit;
        logic [7:0] pol_set;
        logic [7:0] sw_set;
        logic [7:0] new_pol;
        logic hit;
        logic [2:0] ofs;
        lvl = '0;
        prev = '0;
        rise = '0;
        fall = '0;
        edge_hit = '0;
        pol_set = '0;
        sw_set = '0;
        new_pol = '0;
        hit = 1'b0;
        ofs = '0;
        state_nxt = state_r;
        state_nxt.rdata = dio_pkg::READ_UNMAPPED;
        for (int p = 0; p < NP; p++) begin
            lvl = level_now[p*8 +: 8];
            prev = state_r.level_prev[p];
            state_nxt.level_prev[p] = lvl;
            // Peripheral input tracks the pin only while the peripheral owns it.
            for (int b = 0; b < 8; b++) begin
                if (state_r.func_sel[p][b]) begin
                    state_nxt.periph_hold[p][b] = lvl[b];
                end
            end
            hit = (reg_addr_in[7:3] == bases[p][7:3])
                && (reg_addr_in[2] == bases[p][2] || p < NI);
            ofs = reg_addr_in[2:0] - bases[p][2:0];
            if (hit && reg_rd_in) begin
                case (ofs)
                    dio_pkg::OFS_PIN_LEVEL: state_nxt.rdata = lvl;
                    dio_pkg::OFS_OUTPUT_VALUE: state_nxt.rdata = state_r.output_value[p];
                    dio_pkg::OFS_DIRECTION: state_nxt.rdata = state_r.direction[p];
                    default: begin
                        if (p >= NI && ofs == dio_pkg::OFS_FUNC_SEL_PLAIN) begin
                            state_nxt.rdata = state_r.func_sel[p];
                        end else if (p < NI) begin
                            case (ofs)
                                dio_pkg::OFS_EDGE_FLAGS: state_nxt.rdata = state_r.flags[p];
                                dio_pkg::OFS_EDGE_POLARITY: state_nxt.rdata = state_r.polarity[p];
                                dio_pkg::OFS_IRQ_ENABLE: state_nxt.rdata = state_r.irq_enable[p];
                                dio_pkg::OFS_FUNC_SEL_IRQ: state_nxt.rdata = state_r.func_sel[p];
                                default: state_nxt.rdata = dio_pkg::READ_UNMAPPED;
                            endcase
                        end
                    end
                endcase
            end
            if (hit && reg_wr_in) begin
                case (ofs)
                    dio_pkg::OFS_OUTPUT_VALUE: state_nxt.output_value[p] = reg_wdata_in;
                    dio_pkg::OFS_DIRECTION: state_nxt.direction[p] = reg_wdata_in;
                    default: begin
                        if (p >= NI && ofs == dio_pkg::OFS_FUNC_SEL_PLAIN) begin
                            state_nxt.func_sel[p] = reg_wdata_in;
                        end else if (p < NI && ofs == dio_pkg::OFS_FUNC_SEL_IRQ) begin
                            state_nxt.func_sel[p] = reg_wdata_in;
                        end
                    end
                endcase
            end
            // Port function drives output value; peripheral function drives its own data.
            for (int b = 0; b < 8; b++) begin
                state_nxt.pin_drive[p][b] = state_nxt.func_sel[p][b]
                    ? periph_out_in[p*8+b] : state_nxt.output_value[p][b];
            end
            state_nxt.pin_oe[p] = state_nxt.direction[p];
        end
        for (int p = 0; p < NI; p++) begin
            lvl = level_now[p*8 +: 8];
            prev = state_r.level_prev[p];
            // Pin writes loop back through the pad, so they reach the flags as real edges.
            rise = lvl & ~prev;
            fall = ~lvl & prev;
            edge_hit = (state_r.polarity[p] & fall) | (~state_r.polarity[p] & rise);
            hit = (reg_addr_in[7:3] == bases[p][7:3]);
            ofs = reg_addr_in[2:0];
            pol_set = '0;
            sw_set = '0;
            new_pol = state_r.polarity[p];
            if (hit && reg_wr_in) begin
                case (ofs)
                    dio_pkg::OFS_EDGE_FLAGS: begin
                        state_nxt.flags[p] = reg_wdata_in;
                        sw_set = reg_wdata_in;
                    end
                    dio_pkg::OFS_EDGE_POLARITY: begin
                        new_pol = reg_wdata_in;
                        state_nxt.polarity[p] = reg_wdata_in;
                        // Only a real polarity write may set flags; the kept value is unknown at power-up.
                        pol_set = (~state_r.polarity[p] & new_pol & ~lvl)
                            | (state_r.polarity[p] & ~new_pol & lvl);
                    end
                    dio_pkg::OFS_IRQ_ENABLE: state_nxt.irq_enable[p] = reg_wdata_in;
                    default: sw_set = '0;
                endcase
            end
            // Hardware only sets flags, and a set in the clearing cycle wins.
            state_nxt.flags[p] = state_nxt.flags[p]
                | ((edge_hit | pol_set) & ~state_r.func_sel[p]);
            state_nxt.irq[p] = global_irq_enable_in
                && |(state_nxt.flags[p] & state_nxt.irq_enable[p]);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int p = 0; p < NP; p++) begin
                state_r.direction[p] <= dio_pkg::DIRECTION_RST;
                state_r.func_sel[p] <= dio_pkg::FUNC_SEL_RST;
                state_r.pin_oe[p] <= dio_pkg::DIRECTION_RST;
                state_r.level_prev[p] <= '0;
                state_r.periph_hold[p] <= '0;
                state_r.pin_drive[p] <= state_r.output_value[p];
            end
            for (int p = 0; p < NI; p++) begin
                state_r.flags[p] <= dio_pkg::FLAGS_RST;
                state_r.irq_enable[p] <= dio_pkg::IRQ_ENABLE_RST;
            end
            state_r.irq <= '0;
            state_r.rdata <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign reg_rdata_out = state_r.rdata;
    assign pin_out = state_r.pin_drive;
    assign pin_oe_out = state_r.pin_oe;
    assign periph_in_out = state_r.periph_hold;
    assign port_irq_out = state_r.irq;
endmodule

// File: test/dio_pad_model.sv
// Pad model: a driven pin loops its drive level back, an undriven pin shows the outside level.
// Assumes the bench holds each outside level for several clock periods.
`timescale 1ns/100ps
module dio_pad_model #(
    parameter int unsigned WIDTH = 48
) (
    input wire logic [WIDTH-1:0] pin_drive_in,
    input wire logic [WIDTH-1:0] pin_oe_in,
    input wire logic [WIDTH-1:0] ext_level_in,
    output logic [WIDTH-1:0] pin_level_out
);
    assign pin_level_out = (pin_oe_in & pin_drive_in) | (~pin_oe_in & ext_level_in);
endmodule

// File: test/dio_ports_sva.sv
// Checker for the digital I/O port block.
// Sees only the ports of dio_ports; needs at least four ports for the synchroniser check.
`timescale 1ns/100ps
module dio_ports_sva #(
    parameter int unsigned NUM_PORTS = dio_pkg::NUM_PORTS
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [dio_pkg::ADDR_WIDTH-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic global_irq_enable_in,
    input wire logic [NUM_PORTS*8-1:0] pin_in,
    input wire logic [NUM_PORTS*8-1:0] pin_oe_out,
    input wire logic [dio_pkg::NUM_IRQ_PORTS-1:0] port_irq_out
);
    logic [1:0] stable_cnt_r;
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || pin_in[31:24] != $past(pin_in[31:24])) begin
            stable_cnt_r <= 2'h0;
        end else if (stable_cnt_r != 2'h3) begin
            stable_cnt_r <= stable_cnt_r + 2'h1;
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    dir_to_oe_a: assert property (reg_wr_in && reg_addr_in == 8'h22
        |=> pin_oe_out[7:0] == $past(reg_wdata_in)) else $error("direction not on enable");
    port4_dir_a: assert property (reg_wr_in && reg_addr_in == 8'h1E
        |=> pin_oe_out[31:24] == $past(reg_wdata_in)) else $error("port four direction");
    level_ro_a: assert property (reg_wr_in && reg_addr_in == 8'h20
        |=> $stable(pin_oe_out)) else $error("level write changed a pin");
    sel_keeps_dir_a: assert property (reg_wr_in && reg_addr_in == 8'h26
        |=> $stable(pin_oe_out)) else $error("select write changed direction");
    irq_gie_a: assert property (!global_irq_enable_in |=> port_irq_out == 2'h0)
        else $error("request without global enable");
    irq_hold_a: assert property ((!reg_wr_in && global_irq_enable_in)[*4]
        ##0 $past(port_irq_out[0], 3) |=> port_irq_out[0]) else $error("request dropped");
    level_sync_a: assert property (reg_rd_in && reg_addr_in == 8'h1C && stable_cnt_r >= 2'h2
        && pin_in[31:24] == $past(pin_in[31:24]) |=> reg_rdata_out == $past(pin_in[31:24]))
        else $error("level read wrong");
    cover property ($rose(port_irq_out[0]));
    cover property ($rose(port_irq_out[1]));
    cover property (reg_rd_in && reg_addr_in == 8'h1C && stable_cnt_r == 2'h3);
endmodule
bind dio_ports dio_ports_sva #(.NUM_PORTS(NUM_PORTS)) dio_ports_sva_inst (.ref_clk_in,
    .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .global_irq_enable_in, .pin_in, .pin_oe_out, .port_irq_out);

// File: test/dio_ports_test.sv
// Register-level bench for the digital I/O port block with a looped-back pad model.
// Assumes the register map and reset values of dio_pkg.
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("Error %0t: got %h expected %h", $time, (g), (e)); end end
module dio_ports_test;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic global_irq_enable = 1'b0;
    logic [47:0] ext = 48'h0;
    logic [47:0] periph_out = 48'h0;
    logic [7:0] rdata;
    logic [47:0] pin_in, pin_out, pin_oe, periph_in;
    logic [1:0] irq;
    logic [7:0] bases [6] = '{dio_pkg::P1_BASE, dio_pkg::P2_BASE, dio_pkg::P3_BASE,
        dio_pkg::P4_BASE, dio_pkg::P5_BASE, dio_pkg::P6_BASE};
    logic [7:0] rst_ofs [4] = '{8'h02, 8'h03, 8'h05, 8'h06};
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    always #25 ref_clk = ~ref_clk;
    dio_ports dio_ports_inst (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .global_irq_enable_in(global_irq_enable), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe),
        .periph_out_in(periph_out), .periph_in_out(periph_in), .port_irq_out(irq));
    dio_pad_model dio_pad_model_inst (.pin_drive_in(pin_out), .pin_oe_in(pin_oe),
        .ext_level_in(ext), .pin_level_out(pin_in));
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_check(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task automatic set_ext(input logic [47:0] v);
        @(posedge ref_clk);
        ext <= v;
        tick(5);
    endtask
    task automatic final_report;
        $display("Comparisons %0d, errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            final_report;
        end
    end
    initial begin
        tick(10);
        rst_n <= 1'b1;
        `CHK(pin_oe, 48'h0)
        for (int i = 0; i < 2; i++) begin
            for (int j = 0; j < 4; j++) begin
                reg_check(bases[i] + rst_ofs[j], 8'h00);
            end
        end
        for (int i = 0; i < 6; i++) begin
            reg_write(bases[i] + 8'h2, 8'hFF);
            reg_write(bases[i] + 8'h1, bases[i] ^ 8'hA5);
            tick(4);
            `CHK(pin_oe[i*8 +: 8], 8'hFF)
            `CHK(pin_out[i*8 +: 8], bases[i] ^ 8'hA5)
            reg_check(bases[i], bases[i] ^ 8'hA5);
            reg_check(bases[i] + 8'h1, bases[i] ^ 8'hA5);
            reg_write(bases[i] + 8'h2, 8'h00);
        end
        periph_out <= 48'h3C0000;
        reg_write(bases[2] + 8'h2, 8'hFF);
        reg_write(bases[2] + 8'h1, 8'h00);
        reg_write(bases[2] + 8'h3, 8'h0F);
        tick(2);
        `CHK(pin_out[23:16], 8'h0C)
        reg_check(bases[2] + 8'h2, 8'hFF);
        global_irq_enable <= 1'b1;
        tick(4);
        reg_write(bases[0] + 8'h3, 8'h00);
        reg_write(bases[0] + 8'h4, 8'h00);
        reg_write(bases[0] + 8'h5, 8'hFF);
        reg_write(bases[0] + 8'h6, 8'h01);
        set_ext(48'h1);
        `CHK(periph_in[0], 1'b1)
        reg_check(bases[0] + 8'h3, 8'h00);
        reg_write(bases[0] + 8'h6, 8'h00);
        set_ext(48'h0);
        `CHK(periph_in[0], 1'b1)
        reg_check(bases[0] + 8'h3, 8'h00);
        set_ext(48'h2);
        tick(4);
        `CHK(irq, 2'h1)
        reg_check(bases[0] + 8'h3, 8'h02);
        reg_write(bases[0] + 8'h3, 8'h00);
        tick(4);
        `CHK(irq, 2'h0)
        reg_check(bases[0] + 8'h3, 8'h00);
        set_ext(48'h0);
        reg_write(bases[0] + 8'h4, 8'h02);
        reg_check(bases[0] + 8'h3, 8'h02);
        reg_write(bases[0] + 8'h3, 8'h00);
        reg_write(bases[0] + 8'h1, 8'h00);
        reg_write(bases[0] + 8'h2, 8'h04);
        reg_write(bases[0] + 8'h1, 8'h04);
        tick(4);
        reg_check(bases[0] + 8'h3, 8'h04);
        reg_write(bases[0] + 8'h5, 8'h00);
        tick(2);
        `CHK(irq, 2'h0)
        reg_write(bases[0] + 8'h5, 8'hFF);
        tick(2);
        `CHK(irq, 2'h1)
        global_irq_enable <= 1'b0;
        tick(2);
        `CHK(irq, 2'h0)
        global_irq_enable <= 1'b1;
        reg_write(bases[0] + 8'h3, 8'h00);
        reg_write(bases[1] + 8'h3, 8'h80);
        reg_write(bases[1] + 8'h5, 8'h80);
        tick(8);
        `CHK(irq, 2'h2)
        reg_write(bases[0], 8'hFF);
        reg_check(bases[0], 8'h04);
        reg_write(8'h3F, 8'hFF);
        reg_check(8'h3F, dio_pkg::READ_UNMAPPED);
        final_report;
    end
endmodule
